// [pcc_pkg.sv]
// package: register numbers, field positions, reset values and codes for the pll config block
package pcc_pkg;
    localparam int unsigned ADDR_W = 7;                 // register number width
    localparam logic [6:0] REG_LAST = 7'h48;            // last register number (72)
    localparam logic [6:0] REG_FIRST_CLOCK_OUTPUT_CTL = 7'h14;        // 20: first output control
    localparam logic [6:0] REG_ODIV_HI = 7'h16;         // 22: slew, post-div, divider msb
    localparam logic [6:0] REG_ODIV_LO = 7'h17;         // 23: divider low byte
    localparam logic [6:0] REG_SECOND_CLOCK_OUTPUT_CTL = 7'h18;        // 24: second output, ref divider
    localparam logic [6:0] REG_INT_HI = 7'h19;          // 25
    localparam logic [6:0] REG_INT_LO = 7'h1a;          // 26
    localparam logic [6:0] REG_NUM_HI = 7'h1b;          // 27
    localparam logic [6:0] REG_NUM_MID = 7'h1c;         // 28
    localparam logic [6:0] REG_NUM_LO = 7'h1d;          // 29
    localparam logic [6:0] REG_DEN_HI = 7'h1e;          // 30
    localparam logic [6:0] REG_DEN_MID = 7'h1f;         // 31
    localparam logic [6:0] REG_DEN_LO = 7'h20;          // 32
    localparam logic [6:0] REG_MOD = 7'h21;             // 33: modulator order, dither
    localparam logic [6:0] REG_CP = 7'h22;              // 34: charge pump, doubler
    localparam logic [6:0] REG_PHASE = 7'h23;           // 35: phase shift, loop filter select
    localparam logic [6:0] REG_LF_R2 = 7'h24;           // 36
    localparam logic [6:0] REG_LF_C1 = 7'h25;           // 37
    localparam logic [6:0] REG_LF_R3 = 7'h26;           // 38
    localparam logic [6:0] REG_LF_C3 = 7'h27;           // 39
    localparam logic [6:0] REG_STATUS = 7'h42;          // 66: read-only sticky flags
    localparam logic [6:0] REG_CAL = 7'h48;             // 72: recalibration trigger
    localparam int unsigned BIT_FIRST_CLOCK_OUTPUT_EN = 2;            // in register 20
    localparam int unsigned BIT_SECOND_CLOCK_OUTPUT_EN = 4;            // in register 24
    localparam int unsigned BIT_REF_DIV4 = 0;           // in register 24
    localparam int unsigned BIT_POST5 = 5;              // in register 22
    localparam int unsigned BIT_DBL = 5;                // in register 34
    localparam int unsigned BIT_LF_SEL = 2;             // in register 35
    localparam int unsigned BIT_CAL_GO = 1;             // in register 72
    localparam int unsigned BIT_LOL = 0;                // status: loss of lock
    localparam int unsigned BIT_CALF = 1;               // status: calibration done
    localparam logic [1:0] SLEW_FAST = 2'h0;            // register 22 bits 7:6
    localparam logic [1:0] SLEW_SLOW = 2'h2;
    localparam logic [8:0] ODIV_MIN = 9'h006;           // legal output divider range
    localparam logic [8:0] ODIV_MAX = 9'h100;
    localparam logic [11:0] INT_MIN = 12'h001;          // feedback integer lower bound
    localparam logic [21:0] DEN_MIN = 22'h000001;       // denominator lower bound
    // non-volatile defaults; values other than the output enables are arbitrary
    localparam logic [7:0] NV_R20 = 8'h04;              // first output enabled
    localparam logic [7:0] NV_R22 = 8'h00;
    localparam logic [7:0] NV_R23 = 8'h10;              // divide by 16
    localparam logic [7:0] NV_R24 = 8'h00;              // second output tri-stated
    localparam logic [7:0] NV_R26 = 8'h64;              // integer 100
    localparam logic [7:0] NV_R32 = 8'h01;              // denominator 1
    localparam logic [7:0] NV_R34 = 8'h04;              // 6.4 mA slice
    // power-up sequencer
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_CAL_GO = 2'b01,
        ST_CAL_WAIT = 2'b10,
        ST_RUN = 2'b11
    } pcc_state_t;
endpackage

// [pcc_nvmem.sv]
// pcc_nvmem: non-volatile default array with registered read data
`timescale 1ns/10ps
`default_nettype none
module pcc_nvmem (
    input wire logic CLK_I,
    input wire logic [pcc_pkg::ADDR_W-1:0] ADDR_I,
    output logic [7:0] DATA_O
);
    import pcc_pkg::*;

    // read data always come from a flop, one cycle after the address
    always_ff @(posedge CLK_I) begin
        unique case (ADDR_I)
            REG_FIRST_CLOCK_OUTPUT_CTL: DATA_O <= NV_R20;
            REG_ODIV_HI: DATA_O <= NV_R22;
            REG_ODIV_LO: DATA_O <= NV_R23;
            REG_SECOND_CLOCK_OUTPUT_CTL: DATA_O <= NV_R24;
            REG_INT_LO: DATA_O <= NV_R26;
            REG_DEN_LO: DATA_O <= NV_R32;
            REG_CP: DATA_O <= NV_R34;
            default: DATA_O <= 8'h00; // unlisted cells hold zero
        endcase
    end
endmodule
`default_nettype wire

// [pcc_top.sv]
// pcc_top: register file, power-up load, calibration and lock flags for the fractional pll
`timescale 1ns/10ps
`default_nettype none
module pcc_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [pcc_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic REF_PULSE_I,
    input wire logic FB_PULSE_I,
    input wire logic CAL_DONE_I,
    output logic CAL_START_O,
    output logic CAL_BUSY_O,
    output logic READY_O,
    output logic [11:0] FB_INT_O,
    output logic [21:0] FB_NUM_O,
    output logic [21:0] FEEDBACK_DENOMINATOR_O,
    output logic [1:0] MOD_ORDER_O,
    output logic [1:0] DITHER_O,
    output logic [3:0] CP_SLICE_O,
    output logic [2:0] PHASE_SHIFT_O,
    output logic LF_SELECT_O,
    output logic [7:0] LF_R2_O,
    output logic [7:0] LF_C1_O,
    output logic [7:0] LF_R3_O,
    output logic [7:0] LF_C3_O,
    output logic POST_DIV5_O,
    output logic [8:0] OUT_DIV_O,
    output logic SLEW_SLOW_O,
    output logic FIRST_CLOCK_OUTPUT_EN_O,
    output logic SECOND_CLOCK_OUTPUT_EN_O,
    output logic REF_DIV4_O,
    output logic REF_DOUBLER_O
);
    import pcc_pkg::*;

    logic [7:0] regs [0:72];            // configuration byte store
    pcc_state_t state_reg;              // power-up sequencer
    logic [6:0] ld_addr_reg;            // address presented to the default array
    logic ld_valid_reg;                 // array data valid for ld_wr_addr_reg
    logic [6:0] ld_wr_addr_reg;         // register receiving the array byte
    logic [7:0] nv_data;                // default array read data
    logic ld_done_reg;                  // last byte copied, commit all live values
    logic wr_en;                        // merged write port
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic odiv_arm_reg;                 // register 23 written, waiting for 22
    logic [1:0] status_reg;             // sticky status flags
    logic rd_status;                    // status read strobe in this cycle
    logic [2:0] ref_sync_reg;           // two sync flops plus edge history
    logic [2:0] fb_sync_reg;
    logic [2:0] cal_sync_reg;
    logic [1:0] slip_bal_reg;           // ref minus fb edge balance
    logic slip;                         // a slip detected this cycle
    logic cal_req;                      // host asked for recalibration
    logic [11:0] int_cand;
    logic [21:0] num_cand;
    logic [21:0] den_cand;
    logic [8:0] odiv_cand;

    pcc_nvmem u_nvmem (
        .CLK_I(CLK_I),
        .ADDR_I(ld_addr_reg),
        .DATA_O(nv_data)
    );

    // bus writes are ignored while defaults are copied in, so the copy cannot be torn
    always_comb begin
        if (ld_valid_reg) begin
            wr_en = 1'b1;
            wr_addr = ld_wr_addr_reg;
            wr_data = nv_data;
        end else begin
            wr_en = WR_I && (state_reg != ST_LOAD);
            wr_addr = ADDR_I;
            wr_data = WDATA_I;
        end
    end

    // default copy: walk every register number, array answers one cycle later
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ld_addr_reg <= 7'h00;
            ld_valid_reg <= 1'b0;
            ld_wr_addr_reg <= 7'h00;
            ld_done_reg <= 1'b0;
        end else begin
            ld_done_reg <= ld_valid_reg && (ld_wr_addr_reg == REG_LAST);
            ld_valid_reg <= (state_reg == ST_LOAD) && !ld_done_reg
                && !(ld_valid_reg && ld_wr_addr_reg == REG_LAST);
            ld_wr_addr_reg <= ld_addr_reg;
            if (state_reg == ST_LOAD && ld_addr_reg != REG_LAST) begin
                ld_addr_reg <= ld_addr_reg + 7'h01;
            end
        end
    end

    // sequencer: calibration starts only after the copy has finished
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg <= ST_LOAD;
        end else begin
            unique case (state_reg)
                ST_LOAD: begin
                    if (ld_done_reg) begin
                        state_reg <= ST_CAL_GO;
                    end
                end
                ST_CAL_GO: state_reg <= ST_CAL_WAIT;
                ST_CAL_WAIT: begin
                    if (cal_sync_reg[1] && !cal_sync_reg[2]) begin // rising done only, old level is stale
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (cal_req) begin
                        state_reg <= ST_CAL_GO;
                    end
                end
            endcase
        end
    end

    assign cal_req = WR_I && ADDR_I == REG_CAL && WDATA_I[BIT_CAL_GO]
        && state_reg == ST_RUN;
    assign rd_status = RD_I && ADDR_I == REG_STATUS; // flags drop at the edge that samples them
    assign CAL_START_O = (state_reg == ST_CAL_GO);
    assign CAL_BUSY_O = (state_reg == ST_CAL_GO) || (state_reg == ST_CAL_WAIT);
    assign READY_O = (state_reg == ST_RUN);

    // byte store; status is held separately and the trigger bit never sticks
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i <= 72; i++) begin
                regs[i] <= 8'h00;
            end
        end else if (wr_en && wr_addr <= REG_LAST && wr_addr != REG_STATUS) begin
            if (wr_addr == REG_CAL) begin
                regs[wr_addr] <= wr_data & ~(8'h01 << BIT_CAL_GO);
            end else begin
                regs[wr_addr] <= wr_data;
            end
        end
    end

    // candidates for multi-byte fields, taking the byte being written this cycle
    always_comb begin
        int_cand = {regs[REG_INT_HI][3:0], regs[REG_INT_LO]};
        num_cand = {regs[REG_NUM_HI][5:0], regs[REG_NUM_MID], regs[REG_NUM_LO]};
        den_cand = {regs[REG_DEN_HI][5:0], regs[REG_DEN_MID], regs[REG_DEN_LO]};
        odiv_cand = {regs[REG_ODIV_HI][0], regs[REG_ODIV_LO]};
        if (wr_en && wr_addr == REG_INT_LO) begin
            int_cand[7:0] = wr_data;
        end
        if (wr_en && wr_addr == REG_NUM_LO) begin
            num_cand[7:0] = wr_data;
        end
        if (wr_en && wr_addr == REG_DEN_LO) begin
            den_cand[7:0] = wr_data;
        end
        if (wr_en && wr_addr == REG_ODIV_HI) begin
            odiv_cand[8] = wr_data[0];
        end
    end

    // feedback divider: values apply on the low byte so partial updates never reach the pll
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            FB_INT_O <= INT_MIN;
            FB_NUM_O <= 22'h000000;
            FEEDBACK_DENOMINATOR_O <= DEN_MIN;
        end else begin
            if ((ld_done_reg || (wr_en && wr_addr == REG_INT_LO)) && int_cand >= INT_MIN) begin
                FB_INT_O <= int_cand;
            end
            if (ld_done_reg || (wr_en && wr_addr == REG_NUM_LO)) begin
                FB_NUM_O <= num_cand;
            end
            if ((ld_done_reg || (wr_en && wr_addr == REG_DEN_LO)) && den_cand >= DEN_MIN) begin
                FEEDBACK_DENOMINATOR_O <= den_cand;
            end
        end
    end

    // output divider: arm on 23, load on the following 22; out-of-range values are dropped
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            odiv_arm_reg <= 1'b0;
            OUT_DIV_O <= ODIV_MIN;
        end else begin
            if (wr_en && wr_addr == REG_ODIV_LO) begin
                odiv_arm_reg <= 1'b1;
            end else if (ld_done_reg || (wr_en && wr_addr == REG_ODIV_HI)) begin
                odiv_arm_reg <= 1'b0;
            end
            if ((ld_done_reg || (wr_en && wr_addr == REG_ODIV_HI && odiv_arm_reg))
                    && odiv_cand >= ODIV_MIN && odiv_cand <= ODIV_MAX) begin
                OUT_DIV_O <= odiv_cand;
            end
        end
    end

    // single-register controls feed straight from the store
    assign MOD_ORDER_O = regs[REG_MOD][1:0];
    assign DITHER_O = regs[REG_MOD][3:2];
    assign CP_SLICE_O = regs[REG_CP][3:0];
    assign PHASE_SHIFT_O = regs[REG_PHASE][6:4];
    assign LF_SELECT_O = regs[REG_PHASE][BIT_LF_SEL];
    assign LF_R2_O = regs[REG_LF_R2];
    assign LF_C1_O = regs[REG_LF_C1];
    assign LF_R3_O = regs[REG_LF_R3];
    assign LF_C3_O = regs[REG_LF_C3];
    assign POST_DIV5_O = regs[REG_ODIV_HI][BIT_POST5];
    assign SLEW_SLOW_O = (regs[REG_ODIV_HI][7:6] == SLEW_SLOW);
    assign FIRST_CLOCK_OUTPUT_EN_O = regs[REG_FIRST_CLOCK_OUTPUT_CTL][BIT_FIRST_CLOCK_OUTPUT_EN];
    assign SECOND_CLOCK_OUTPUT_EN_O = regs[REG_SECOND_CLOCK_OUTPUT_CTL][BIT_SECOND_CLOCK_OUTPUT_EN];
    assign REF_DIV4_O = regs[REG_SECOND_CLOCK_OUTPUT_CTL][BIT_REF_DIV4];
    assign REF_DOUBLER_O = regs[REG_CP][BIT_DBL];

    // pin synchronisers; edges are taken from flops 1 and 2 only
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ref_sync_reg <= 3'h0;
            fb_sync_reg <= 3'h0;
            cal_sync_reg <= 3'h0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[1:0], REF_PULSE_I};
            fb_sync_reg <= {fb_sync_reg[1:0], FB_PULSE_I};
            cal_sync_reg <= {cal_sync_reg[1:0], CAL_DONE_I};
        end
    end

    // slip detector: two edges of one path with none of the other is a lost cycle
    logic ref_edge;
    logic fb_edge;
    assign ref_edge = ref_sync_reg[1] && !ref_sync_reg[2];
    assign fb_edge = fb_sync_reg[1] && !fb_sync_reg[2];
    assign slip = (ref_edge && !fb_edge && slip_bal_reg == 2'h1)
        || (fb_edge && !ref_edge && slip_bal_reg == 2'h3);
    always_ff @(posedge CLK_I) begin
        if (RST_I || slip || state_reg != ST_RUN) begin
            slip_bal_reg <= 2'h0; // detector only runs once calibrated
        end else if (ref_edge && !fb_edge) begin
            slip_bal_reg <= slip_bal_reg + 2'h1;
        end else if (fb_edge && !ref_edge) begin
            slip_bal_reg <= slip_bal_reg - 2'h1;
        end
    end

    // sticky flags clear on the read edge itself, so an event during the read is kept
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status_reg <= 2'h0;
        end else begin
            status_reg[BIT_LOL] <= slip || (status_reg[BIT_LOL] && !rd_status);
            status_reg[BIT_CALF] <= (state_reg == ST_CAL_WAIT && cal_sync_reg[1]
                && !cal_sync_reg[2]) || (status_reg[BIT_CALF] && !rd_status);
        end
    end

    // read port: data in the cycle after the strobe; numbers above 72 read zero
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RDATA_O <= 8'h00;
        end else if (RD_I) begin
            if (ADDR_I == REG_STATUS) begin
                RDATA_O <= {6'h00, status_reg};
            end else if (ADDR_I <= REG_LAST) begin
                RDATA_O <= regs[ADDR_I];
            end else begin
                RDATA_O <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    cal_after_load_a: assert property ($rose(CAL_START_O)
        |-> $past(ld_done_reg, 1) || $past(cal_req, 1))
        else $error("calibration started without load or request");
    cal_request_a: assert property (cal_req |=> CAL_START_O ##1 CAL_BUSY_O)
        else $error("recalibration request not served");
    num_hold_a: assert property (wr_en && wr_addr == REG_NUM_HI && !ld_done_reg
        |=> $stable(FB_NUM_O))
        else $error("numerator changed on upper byte");
    num_commit_a: assert property (wr_en && wr_addr == REG_NUM_LO
        |=> FB_NUM_O == $past(num_cand))
        else $error("numerator not committed");
    int_range_a: assert property (FB_INT_O >= INT_MIN)
        else $error("feedback integer zero");
    div_range_a: assert property (OUT_DIV_O >= ODIV_MIN && OUT_DIV_O <= ODIV_MAX)
        else $error("output divider out of range");
    div_order_a: assert property (wr_en && wr_addr == REG_ODIV_HI && !odiv_arm_reg && !ld_done_reg
        |=> $stable(OUT_DIV_O))
        else $error("divider loaded without prior low byte");
    slip_flag_a: assert property (slip |=> status_reg[BIT_LOL])
        else $error("slip not flagged");
    clear_read_a: assert property (rd_status && !slip |=> !status_reg[BIT_LOL])
        else $error("loss of lock not cleared by read");
    ro_status_a: assert property (WR_I && ADDR_I == REG_STATUS && !slip && !rd_status
        |=> $stable(status_reg[BIT_LOL]))
        else $error("write changed read-only flag");
    slew_map_a: assert property (wr_en && wr_addr == REG_ODIV_HI
        |=> SLEW_SLOW_O == ($past(wr_data[7:6]) == SLEW_SLOW))
        else $error("slew select mismatch");

    load_cover_c: cover property (ld_done_reg ##[1:300] READY_O);
    recal_cover_c: cover property (READY_O && cal_req ##[1:50] READY_O);
    slip_read_c: cover property (slip ##[1:20] rd_status);
    div_pair_c: cover property (wr_en && wr_addr == REG_ODIV_LO ##1 wr_en && wr_addr == REG_ODIV_HI);
endmodule
`default_nettype wire

// [pcc_pll_model.sv]
// pcc_pll_model: analog pll stand-in giving the calibration handshake and pfd pulses
`timescale 1ns/10ps
`default_nettype none
module pcc_pll_model #(
    parameter int CAL_CYCLES = 12 // calibration length, plain default
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cal_start_i,
    input wire logic slip_i,
    output logic cal_done_o,
    output logic ref_pulse_o,
    output logic fb_pulse_o
);
    logic [7:0] cal_cnt_reg; // cycles left in the running calibration
    logic [2:0] ph_reg; // phase within one 8-cycle pfd period
    logic skip_reg; // swallow the next feedback pulse
    // calibration: done drops on start, rises after a fixed time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_cnt_reg <= 8'h00;
            cal_done_o <= 1'b0;
        end else if (cal_start_i) begin
            cal_cnt_reg <= 8'(CAL_CYCLES);
            cal_done_o <= 1'b0;
        end else if (cal_cnt_reg > 8'h01) begin
            cal_cnt_reg <= cal_cnt_reg - 8'h01;
        end else if (cal_cnt_reg == 8'h01) begin
            cal_cnt_reg <= 8'h00;
            cal_done_o <= 1'b1;
        end
    end
    // pulses: ref at phase 0, feedback at phase 4; a slip drops one feedback pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg <= 3'h0;
            skip_reg <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 3'h1;
            if (slip_i) begin
                skip_reg <= 1'b1;
            end else if (ph_reg == 3'h4) begin
                skip_reg <= 1'b0;
            end
        end
    end
    assign ref_pulse_o = !rst_i && (ph_reg == 3'h0);
    assign fb_pulse_o = !rst_i && (ph_reg == 3'h4) && !skip_reg;
endmodule
`default_nettype wire

// [tb_pll_config_control.sv]
// tb_pll_config_control: register-level tests of the pll config block
`timescale 1ns/10ps
`default_nettype none
module tb_pll_config_control;
    import pcc_pkg::*;
    logic CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, SLIP = 0;
    logic [6:0] ADDR_I = 7'h00;
    logic [7:0] WDATA_I = 8'h00, RDATA_O;
    logic REF_P, FB_P, CAL_DONE, CAL_START_O, CAL_BUSY_O, READY_O, LF_SEL, POST5, SLEW_SLOW;
    logic EN0, EN1, RDIV4, DBL;
    logic [11:0] FB_INT_O;
    logic [21:0] FB_NUM_O, FB_DEN;
    logic [1:0] MOD_ORDER_O, DITHER_O;
    logic [3:0] CP_SLICE_O;
    logic [2:0] PHASE_SHIFT_O;
    logic [7:0] LF [4];
    logic [8:0] OUT_DIV_O;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    logic [7:0] d;
    initial forever #5 CLK_I = ~CLK_I;
    pcc_top uut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .RDATA_O(RDATA_O), .REF_PULSE_I(REF_P), .FB_PULSE_I(FB_P),
        .CAL_DONE_I(CAL_DONE), .CAL_START_O(CAL_START_O), .CAL_BUSY_O(CAL_BUSY_O),
        .READY_O(READY_O), .FB_INT_O(FB_INT_O), .FB_NUM_O(FB_NUM_O),
        .FEEDBACK_DENOMINATOR_O(FB_DEN), .MOD_ORDER_O(MOD_ORDER_O), .DITHER_O(DITHER_O),
        .CP_SLICE_O(CP_SLICE_O), .PHASE_SHIFT_O(PHASE_SHIFT_O), .LF_SELECT_O(LF_SEL),
        .LF_R2_O(LF[0]), .LF_C1_O(LF[1]), .LF_R3_O(LF[2]), .LF_C3_O(LF[3]), .POST_DIV5_O(POST5),
        .OUT_DIV_O(OUT_DIV_O), .SLEW_SLOW_O(SLEW_SLOW), .FIRST_CLOCK_OUTPUT_EN_O(EN0),
        .SECOND_CLOCK_OUTPUT_EN_O(EN1), .REF_DIV4_O(RDIV4), .REF_DOUBLER_O(DBL));
    pcc_pll_model pll (.clk_i(CLK_I), .rst_i(RST_I), .cal_start_i(CAL_START_O), .slip_i(SLIP),
        .cal_done_o(CAL_DONE), .ref_pulse_o(REF_P), .fb_pulse_o(FB_P));
    // compare one value; four-state equality so unknowns never match
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle write strobe; outputs settle just after the taking edge
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge CLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= v;
        @(posedge CLK_I);
        WR_I <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe; data stands from the following cycle until the next read
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(posedge CLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 v = RDATA_O;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 400 && READY_O !== 1'b1; i++) @(posedge CLK_I);
        chk("ready", READY_O, 1);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard: whole run needs well under 3000 cycles
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        wait_ready(); // the copied defaults are checked before this host writes any register
        chk("en0", EN0, 1);
        chk("en1", EN1, 0);
        chk("int", FB_INT_O, 100);
        chk("odiv", OUT_DIV_O, 16);
        chk("cp", CP_SLICE_O, 4);
        rd(REG_STATUS, d);
        chk("stat_pu", d, 8'h02);
        rd(REG_STATUS, d);
        chk("stat_clr", d, 8'h00);
        wr(REG_INT_HI, 8'h0f); // unused upper bits stay zero
        wr(REG_INT_LO, 8'hff);
        chk("int_max", FB_INT_O, 12'hfff);
        wr(REG_INT_HI, 8'h00);
        wr(REG_INT_LO, 8'h00);
        chk("int_zero", FB_INT_O, 12'hfff);
        wr(REG_DEN_HI, 8'h3f);
        wr(REG_DEN_MID, 8'hff);
        wr(REG_DEN_LO, 8'hff);
        chk("den_max", FB_DEN, 22'h3fffff);
        wr(REG_NUM_HI, 8'h12);
        wr(REG_NUM_MID, 8'h34);
        chk("num_hold", FB_NUM_O, 22'h0);
        wr(REG_NUM_LO, 8'h56);
        chk("num", FB_NUM_O, 22'h123456);
        for (int i = 0; i < 16; i++) begin
            wr(REG_MOD, 8'(i));
            chk("order", MOD_ORDER_O, i % 4);
            chk("dither", DITHER_O, i / 4);
        end
        wr(REG_CP, 8'h21);
        chk("cp", CP_SLICE_O, 1);
        chk("dbl", DBL, 1);
        wr(REG_PHASE, 8'h24); // phase shift 2, loop filter select on
        chk("phase", PHASE_SHIFT_O, 2);
        chk("lfsel", LF_SEL, 1);
        for (int k = 0; k < 4; k++) wr(REG_LF_R2 + 7'(k), 8'h11 * 8'(k + 1));
        for (int k = 0; k < 4; k++) chk("lf", LF[k], 8'h11 * 8'(k + 1));
        wr(REG_ODIV_LO, 8'h00);
        wr(REG_ODIV_HI, 8'h80);
        chk("odiv_zero", OUT_DIV_O, 16);
        chk("slew_slow", SLEW_SLOW, 1);
        wr(REG_ODIV_HI, 8'h81); // 256 would be legal, but no low byte came first
        chk("odiv_alone", OUT_DIV_O, 16);
        wr(REG_ODIV_LO, 8'h00);
        chk("odiv_half", OUT_DIV_O, 16);
        wr(REG_ODIV_HI, 8'h21);
        chk("odiv_256", OUT_DIV_O, 256);
        chk("post5", POST5, 1);
        chk("slew_fast", SLEW_SLOW, 0);
        wr(REG_ODIV_LO, 8'h05);
        wr(REG_ODIV_HI, 8'h00);
        chk("odiv_5", OUT_DIV_O, 256);
        wr(REG_ODIV_LO, 8'h06);
        wr(REG_ODIV_HI, 8'h00);
        chk("odiv_6", OUT_DIV_O, 6);
        chk("post4", POST5, 0);
        wr(REG_FIRST_CLOCK_OUTPUT_CTL, 8'h00);
        wr(REG_SECOND_CLOCK_OUTPUT_CTL, 8'h11);
        chk("en0_off", EN0, 0);
        chk("en1_on", EN1, 1);
        chk("rdiv4", RDIV4, 1);
        wr(REG_CAL, 8'h02); // recalibrate after reconfiguring
        chk("cal_go", CAL_START_O, 1);
        chk("cal_busy", CAL_BUSY_O, 1);
        wait_ready();
        chk("cal_idle", CAL_BUSY_O, 0);
        rd(REG_CAL, d);
        chk("cal_bit", d, 8'h00);
        rd(REG_STATUS, d);
        chk("stat_cal", d, 8'h02);
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, d);
        chk("stat_ro", d, 8'h00);
        @(posedge CLK_I);
        SLIP <= 1'b1;
        @(posedge CLK_I);
        SLIP <= 1'b0;
        repeat (30) @(posedge CLK_I);
        rd(REG_STATUS, d);
        chk("slip", d, 8'h01);
        rd(REG_STATUS, d);
        chk("slip_clr", d, 8'h00);
        wr(7'h50, 8'haa);
        rd(7'h50, d);
        chk("unmapped", d, 8'h00);
        rd(REG_LF_R3, d);
        chk("lf_rb", d, 8'h33);
        conclude();
    end
endmodule
`default_nettype wire
